// File: src/phy_link_monitor_rgmii_cfg_regs.v
// Behaviour
// - enhanced receive bit drives feature enable
// - force enable off means automatic polarity
// - forced value 0 normal, 1 inverted
// - metric selects monitored link-up source
// - six-bit mask gates failure logging
// - two-bit code selects comm-ready hysteresis
// - SQI worse than threshold counts failure
// - six-bit link loss count, read only
// - ten-bit failure-without-loss count, read only
// - read-only comm-ready status bit
// - eight-bit last training duration
// - three-bit transmit FIFO threshold, default 3
// - RGMII enable, reset from strap c
// - transmit wire order reversal
// - receive wire order reversal
// - mask transmit error from MAC
// - separate FIFO overflow and underflow flags
// - receive clock shift, strap reset 11
// - transmit clock shift, strap 101/110
// - low-power exit control and data signalling
`timescale 1ns/1ps
`include "phy_link_monitor_regs.vh"
module phy_link_monitor_rgmii_cfg_regs #(
  parameter [15:0] HYST_2MS_CYC   = `HYST_2MS_US * `CLK_FREQ_MHZ,
  parameter [15:0] HYST_500US_CYC = `HYST_500US_US * `CLK_FREQ_MHZ,
  parameter [15:0] HYST_1MS_CYC   = `HYST_1MS_US * `CLK_FREQ_MHZ,
  parameter [15:0] HYST_4MS_CYC   = `HYST_4MS_US * `CLK_FREQ_MHZ,
  parameter [15:0] TRAIN_TICK_CYC = `TRAIN_TICK_US * `CLK_FREQ_MHZ
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire [11:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        strap_pin_a,
  input  wire        strap_pin_b,
  input  wire        strap_pin_c,
  output wire        enhanced_rx_en,
  input  wire        auto_polarity,
  output wire        line_polarity,
  input  wire        link_up_conform,
  input  wire        link_monitor_up,
  input  wire        phy_send_data,
  input  wire        comm_ready_raw,
  output wire        comm_ready,
  output wire        link_up_sel,
  input  wire [2:0]  sqi_value,
  input  wire [3:0]  fail_event,
  input  wire        training_active,
  output wire [2:0]  tx_sync_fifo_threshold,
  input  wire        tx_fifo_overflow,
  input  wire        tx_fifo_underflow,
  output wire        rgmii_enable,
  output wire        rx_clk_shift,
  output wire        tx_clk_shift,
  input  wire [3:0]  mac_txd,
  input  wire        mac_tx_en,
  input  wire        mac_tx_er,
  output reg  [3:0]  pcs_txd,
  output reg         pcs_tx_en,
  output reg         pcs_tx_er,
  input  wire [3:0]  pcs_rxd,
  input  wire        pcs_rx_ctl,
  input  wire        lpi_exit,
  output reg  [3:0]  rgmii_rxd,
  output reg         rgmii_rx_ctl
);

  reg  [15:0] rx_feature_ff;
  reg  [15:0] line_pol_ff;
  reg  [15:0] link_cfg_ff;
  reg  [15:0] rgmii_ctrl_ff;
  reg  [1:0]  clk_skew_ff;
  reg  [1:0]  lpi_sig_ff;
  reg  [15:0] serial_mac_ff;
  reg         strap_done_ff;
  reg         ovf_flag_ff;
  reg         unf_flag_ff;
  reg         comm_ready_ff;
  reg  [15:0] hyst_cnt_ff;
  reg         sqi_worse_ff;
  reg         link_prev_ff;
  reg         train_prev_ff;
  reg  [15:0] tick_cnt_ff;
  reg  [7:0]  train_time_ff;
  reg  [15:0] nxt_rdata;
  reg  [15:0] hyst_limit;
  reg         link_sel;

  wire        wr_rx_feat;
  wire        wr_line_pol;
  wire        wr_link_cfg;
  wire        wr_rgmii_ctl;
  wire        wr_clk_skew;
  wire        wr_lpi;
  wire        wr_serial;
  wire        rd_fifo_err;
  wire [1:0]  metric;
  wire [5:0]  fail_mask;
  wire [1:0]  hyst_code;
  wire [2:0]  sqi_thr;
  wire        sqi_worse;
  wire        fail_pulse;
  wire        loss_pulse;
  wire        tick;
  wire        train_start;
  wire        train_end;
  wire [5:0]  loss_count;
  wire [9:0]  fail_count;
  wire [7:0]  train_count;
  wire [3:0]  txd_ordered;
  wire [3:0]  rxd_ordered;

  assign wr_rx_feat   = reg_wr && (reg_addr == `REG_RX_FEATURE);
  assign wr_line_pol  = reg_wr && (reg_addr == `REG_LINE_POLARITY);
  assign wr_link_cfg  = reg_wr && (reg_addr == `REG_LINK_MON_CFG);
  assign wr_rgmii_ctl = reg_wr && (reg_addr == `REG_RGMII_CTRL);
  assign wr_clk_skew  = reg_wr && (reg_addr == `REG_RGMII_CLK_SKEW);
  assign wr_lpi       = reg_wr && (reg_addr == `REG_RGMII_LPI);
  assign wr_serial    = reg_wr && (reg_addr == `REG_SERIAL_MAC_ONE);
  assign rd_fifo_err  = reg_rd && (reg_addr == `REG_RGMII_FIFO_ERR);

  // writable storage; straps are taken on the first enabled edge after
  // reset, since an async reset may only load constants
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_feature_ff <= `RST_RX_FEATURE;
      line_pol_ff   <= `RST_LINE_POLARITY;
      link_cfg_ff   <= `RST_LINK_MON_CFG;
      rgmii_ctrl_ff <= `RST_RGMII_CTRL;
      clk_skew_ff   <= 2'b00;
      lpi_sig_ff    <= 2'b00;
      serial_mac_ff <= `RST_SERIAL_MAC_ONE;
      strap_done_ff <= 1'b0;
    end else if (ce) begin
      if (!strap_done_ff) begin
        strap_done_ff <= 1'b1;
        rgmii_ctrl_ff[`BIT_RGMII_EN] <= strap_pin_c;
        clk_skew_ff[`BIT_RX_CLK_SHIFT] <= strap_pin_c && strap_pin_b;
        clk_skew_ff[`BIT_TX_CLK_SHIFT] <= strap_pin_c && (strap_pin_b != strap_pin_a);
      end else begin
        if (wr_rx_feat) begin
          rx_feature_ff <= reg_wdata;
        end
        if (wr_line_pol) begin
          line_pol_ff <= reg_wdata;
        end
        if (wr_link_cfg) begin
          link_cfg_ff <= reg_wdata & `WMASK_LINK_MON_CFG;
        end
        if (wr_rgmii_ctl) begin
          rgmii_ctrl_ff <= reg_wdata & `WMASK_RGMII_CTRL;
        end
        if (wr_clk_skew) begin
          clk_skew_ff <= reg_wdata[1:0];
        end
        if (wr_lpi) begin
          lpi_sig_ff <= reg_wdata[1:0];
        end
        if (wr_serial) begin
          serial_mac_ff <= reg_wdata;
        end
      end
    end
  end

  assign enhanced_rx_en = rx_feature_ff[`BIT_ENHANCED_RX];
  assign line_polarity  = line_pol_ff[`BIT_FORCE_POL_EN] ?
                          line_pol_ff[`BIT_FORCE_POL_VAL] : auto_polarity;

  assign metric    = link_cfg_ff[`FLD_LINK_METRIC_HI:`FLD_LINK_METRIC_LO];
  assign fail_mask = link_cfg_ff[`FLD_FAIL_MASK_HI:`FLD_FAIL_MASK_LO];
  assign hyst_code = link_cfg_ff[`FLD_COMM_TIMER_HI:`FLD_COMM_TIMER_LO];
  assign sqi_thr   = link_cfg_ff[`FLD_SQI_THR_HI:`FLD_SQI_THR_LO];

  always @* begin
    case (metric)
      `METRIC_CONFORM:   link_sel = link_up_conform;
      `METRIC_MONITOR:   link_sel = link_monitor_up;
      `METRIC_SEND_DATA: link_sel = phy_send_data;
      default:           link_sel = comm_ready_ff;
    endcase
  end

  always @* begin
    case (hyst_code)
      `HYST_CODE_2MS:   hyst_limit = HYST_2MS_CYC;
      `HYST_CODE_500US: hyst_limit = HYST_500US_CYC;
      `HYST_CODE_1MS:   hyst_limit = HYST_1MS_CYC;
      default:          hyst_limit = HYST_4MS_CYC;
    endcase
  end

  // comm-ready drops at once but must see the raw level steady for the
  // selected time before it rises, so short flickers never reach software
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hyst_cnt_ff   <= 16'h0000;
      comm_ready_ff <= 1'b0;
    end else if (ce) begin
      if (!comm_ready_raw) begin
        hyst_cnt_ff   <= 16'h0000;
        comm_ready_ff <= 1'b0;
      end else if (hyst_cnt_ff >= hyst_limit - 16'h0001) begin
        comm_ready_ff <= 1'b1;
      end else begin
        hyst_cnt_ff <= hyst_cnt_ff + 16'h0001;
      end
    end
  end

  assign comm_ready  = comm_ready_ff;
  assign link_up_sel = link_sel;

  // lower SQI means poorer signal; only the entry into the bad region counts
  assign sqi_worse  = sqi_value < sqi_thr;
  assign fail_pulse = (sqi_worse && !sqi_worse_ff && fail_mask[0]) ||
                      (|(fail_event & fail_mask[4:1]));
  assign loss_pulse = link_prev_ff && !link_sel;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sqi_worse_ff  <= 1'b0;
      link_prev_ff  <= 1'b0;
      train_prev_ff <= 1'b0;
    end else if (ce) begin
      sqi_worse_ff  <= sqi_worse;
      link_prev_ff  <= link_sel;
      train_prev_ff <= training_active;
    end
  end

  sat_event_counter #(.WIDTH(6)) u_loss_count (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (1'b0),
    .inc     (loss_pulse),
    .count   (loss_count)
  );

  // a failure in the same cycle as the link dropping is a loss, not a failure
  sat_event_counter #(.WIDTH(10)) u_fail_count (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (1'b0),
    .inc     (fail_pulse && link_sel),
    .count   (fail_count)
  );

  // training time in ticks of TRAIN_TICK_CYC, captured when training ends
  assign train_start = training_active && !train_prev_ff;
  assign train_end   = !training_active && train_prev_ff;
  assign tick = training_active && (tick_cnt_ff == TRAIN_TICK_CYC - 16'h0001);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (!training_active || tick) begin
        tick_cnt_ff <= 16'h0000;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      end
    end
  end

  sat_event_counter #(.WIDTH(8)) u_train_count (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (train_start),
    .inc     (tick),
    .count   (train_count)
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      train_time_ff <= 8'h00;
    end else if (ce && train_end) begin
      train_time_ff <= train_count;
    end
  end

  // fifo error flags stick until read; an event in the read cycle survives
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_flag_ff <= 1'b0;
      unf_flag_ff <= 1'b0;
    end else if (ce) begin
      ovf_flag_ff <= tx_fifo_overflow || (ovf_flag_ff && !rd_fifo_err);
      unf_flag_ff <= tx_fifo_underflow || (unf_flag_ff && !rd_fifo_err);
    end
  end

  assign tx_sync_fifo_threshold = rgmii_ctrl_ff[`FLD_TX_THR_HI:`FLD_TX_THR_LO];
  assign rgmii_enable = rgmii_ctrl_ff[`BIT_RGMII_EN];
  assign rx_clk_shift = clk_skew_ff[`BIT_RX_CLK_SHIFT];
  assign tx_clk_shift = clk_skew_ff[`BIT_TX_CLK_SHIFT];

  assign txd_ordered = rgmii_ctrl_ff[`BIT_INV_TXD] ?
                       {mac_txd[0], mac_txd[1], mac_txd[2], mac_txd[3]} : mac_txd;
  assign rxd_ordered = rgmii_ctrl_ff[`BIT_INV_RXD] ?
                       {pcs_rxd[0], pcs_rxd[1], pcs_rxd[2], pcs_rxd[3]} : pcs_rxd;

  // data paths are registered; a disabled interface presents all zeros
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcs_txd      <= 4'h0;
      pcs_tx_en    <= 1'b0;
      pcs_tx_er    <= 1'b0;
      rgmii_rxd    <= 4'h0;
      rgmii_rx_ctl <= 1'b0;
    end else if (ce) begin
      if (!rgmii_enable) begin
        pcs_txd      <= 4'h0;
        pcs_tx_en    <= 1'b0;
        pcs_tx_er    <= 1'b0;
        rgmii_rxd    <= 4'h0;
        rgmii_rx_ctl <= 1'b0;
      end else begin
        pcs_txd   <= txd_ordered;
        pcs_tx_en <= mac_tx_en;
        pcs_tx_er <= mac_tx_er && !rgmii_ctrl_ff[`BIT_TX_ERR_MASK];
        if (lpi_exit) begin
          rgmii_rx_ctl <= lpi_sig_ff[`BIT_LPI_EXIT_ERR];
          rgmii_rxd    <= lpi_sig_ff[`BIT_LPI_EXIT_ZERO] ? 4'h0 : `LPI_IDLE_CODE;
        end else begin
          rgmii_rx_ctl <= pcs_rx_ctl;
          rgmii_rxd    <= rxd_ordered;
        end
      end
    end
  end

  always @* begin
    nxt_rdata = 16'h0000;
    if (reg_addr == `REG_RX_FEATURE) begin
      nxt_rdata = rx_feature_ff;
    end else if (reg_addr == `REG_LINE_POLARITY) begin
      nxt_rdata = line_pol_ff;
    end else if (reg_addr == `REG_LINK_MON_CFG) begin
      nxt_rdata = link_cfg_ff;
    end else if (reg_addr == `REG_LINK_FAIL_LOSS) begin
      nxt_rdata = {loss_count, fail_count};
    end else if (reg_addr == `REG_LINK_TRAIN_TIME) begin
      nxt_rdata = {comm_ready_ff, 7'h00, train_time_ff};
    end else if (reg_addr == `REG_RGMII_CTRL) begin
      nxt_rdata = rgmii_ctrl_ff;
    end else if (reg_addr == `REG_RGMII_FIFO_ERR) begin
      nxt_rdata = {14'h0000, ovf_flag_ff, unf_flag_ff};
    end else if (reg_addr == `REG_RGMII_CLK_SKEW) begin
      nxt_rdata = {14'h0000, clk_skew_ff};
    end else if (reg_addr == `REG_RGMII_LPI) begin
      nxt_rdata = {14'h0000, lpi_sig_ff};
    end else if (reg_addr == `REG_SERIAL_MAC_ONE) begin
      nxt_rdata = serial_mac_ff;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? nxt_rdata : 16'h0000;
    end
  end

endmodule

// File: src/phy_link_monitor_regs.vh
`ifndef PHY_LINK_MONITOR_REGS_VH
`define PHY_LINK_MONITOR_REGS_VH

// register indices on the management port
`define REG_RX_FEATURE       12'h4a0
`define REG_LINE_POLARITY    12'h553
`define REG_LINK_MON_CFG     12'h560
`define REG_LINK_FAIL_LOSS   12'h561
`define REG_LINK_TRAIN_TIME  12'h562
`define REG_RGMII_CTRL       12'h600
`define REG_RGMII_FIFO_ERR   12'h601
`define REG_RGMII_CLK_SKEW   12'h602
`define REG_RGMII_LPI        12'h603
`define REG_SERIAL_MAC_ONE   12'h608

// reset values
`define RST_RX_FEATURE       16'h1000
`define RST_LINE_POLARITY    16'h0000
`define RST_LINK_MON_CFG     16'h07e4
`define RST_RGMII_CTRL       16'h0030
`define RST_SERIAL_MAC_ONE   16'h007b

// writable masks
`define WMASK_LINK_MON_CFG   16'h3fff
`define WMASK_RGMII_CTRL     16'h007f

// field positions
`define BIT_ENHANCED_RX      7
`define BIT_FORCE_POL_EN     13
`define BIT_FORCE_POL_VAL    12
`define FLD_LINK_METRIC_HI   12
`define FLD_LINK_METRIC_LO   11
`define FLD_FAIL_MASK_HI     10
`define FLD_FAIL_MASK_LO     5
`define FLD_COMM_TIMER_HI    4
`define FLD_COMM_TIMER_LO    3
`define FLD_SQI_THR_HI       2
`define FLD_SQI_THR_LO       0
`define FLD_TX_THR_HI        6
`define FLD_TX_THR_LO        4
`define BIT_RGMII_EN         3
`define BIT_INV_TXD          2
`define BIT_INV_RXD          1
`define BIT_TX_ERR_MASK      0
`define BIT_RX_CLK_SHIFT     1
`define BIT_TX_CLK_SHIFT     0
`define BIT_LPI_EXIT_ERR     1
`define BIT_LPI_EXIT_ZERO    0

// link-up source codes
`define METRIC_CONFORM       2'b00
`define METRIC_MONITOR       2'b01
`define METRIC_SEND_DATA     2'b10
`define METRIC_COMM_READY    2'b11

// hysteresis codes
`define HYST_CODE_2MS        2'b00
`define HYST_CODE_500US      2'b01
`define HYST_CODE_1MS        2'b10
`define HYST_CODE_4MS        2'b11

// timing
`define CLK_FREQ_MHZ         16'h000a
`define HYST_2MS_US          16'h07d0
`define HYST_500US_US        16'h01f4
`define HYST_1MS_US          16'h03e8
`define HYST_4MS_US          16'h0fa0
`define TRAIN_TICK_US        16'h03e8

// receive data shown during low-power idle exit when not zeroed
`define LPI_IDLE_CODE        4'h1

`endif

// File: src/sat_event_counter.v
`timescale 1ns/1ps
// counts single-cycle events, sticks at all ones instead of wrapping
module sat_event_counter #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             ce,
  input  wire             clr,
  input  wire             inc,
  output wire [WIDTH-1:0] count
);

  reg  [WIDTH-1:0] count_ff;
  reg  [WIDTH-1:0] nxt_count;

  always @* begin
    nxt_count = count_ff;
    if (clr) begin
      nxt_count = {WIDTH{1'b0}};
    end else if (inc && (count_ff != {WIDTH{1'b1}})) begin
      nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= {WIDTH{1'b0}};
    end else if (ce) begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

endmodule

// File: test/link_monitor_assertions.sv
`timescale 1ns/1ps
module link_monitor_checker (
  input wire        clk,
  input wire        sys_rst,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        comm_ready_raw,
  input wire        comm_ready,
  input wire        link_up_sel,
  input wire        link_up_conform,
  input wire        link_monitor_up,
  input wire        phy_send_data,
  input wire        rgmii_enable,
  input wire        mac_tx_en,
  input wire        mac_tx_er,
  input wire        pcs_tx_en,
  input wire        pcs_tx_er,
  input wire [3:0]  pcs_txd,
  input wire        lpi_exit,
  input wire [3:0]  rgmii_rxd,
  input wire        rgmii_rx_ctl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // clock enable is held high by the bench, so every edge is a working edge
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not zero outside a read reply");
  tx_off_a: assert property (!rgmii_enable |=> pcs_txd == 4'h0 && !pcs_tx_en && !pcs_tx_er)
    else $error("transmit path active while interface off");
  rx_off_a: assert property (!rgmii_enable |=> rgmii_rxd == 4'h0 && !rgmii_rx_ctl)
    else $error("receive path active while interface off");
  txen_pass_a: assert property (pcs_tx_en |-> $past(mac_tx_en))
    else $error("transmit enable without a request");
  txer_pass_a: assert property (pcs_tx_er |-> $past(mac_tx_er))
    else $error("transmit error without a request");
  lpi_data_a: assert property (lpi_exit |=> rgmii_rxd inside {4'h0, 4'h1})
    else $error("wrong receive data during low power exit");
  ready_fall_a: assert property (!comm_ready_raw |=> !comm_ready)
    else $error("comm ready held after raw drop");
  ready_rise_a: assert property ($rose(comm_ready) |-> $past(comm_ready_raw) &&
      $past(comm_ready_raw, 2) && $past(comm_ready_raw, 3) && $past(comm_ready_raw, 4))
    else $error("comm ready rose too early");
  link_sel_a: assert property (link_up_sel |->
      link_up_conform || link_monitor_up || phy_send_data || comm_ready)
    else $error("link up without a source");
  cover property (reg_rd ##1 reg_rdata != 16'h0);
  cover property ($rose(comm_ready));
  cover property (pcs_tx_en && pcs_tx_er);
  cover property (rgmii_enable && lpi_exit);
endmodule

// File: test/mac_tx_model.sv
`timescale 1ns/1ps
module mac_tx_model (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       active,
  output reg  [3:0] mac_txd,
  output reg        mac_tx_en,
  output reg        mac_tx_er
);
  integer    seed = 99;
  reg [31:0] r;
  initial begin
    mac_txd = 4'h0;
    mac_tx_en = 1'b0;
    mac_tx_er = 1'b0;
  end
  always @(posedge clk) begin
    r = $random(seed);
    // idle data keeps toggling so a stale nibble never looks like a fresh one
    mac_txd <= (sys_rst || !active) ? ~mac_txd : r[3:0];
    mac_tx_en <= active & r[4];
    mac_tx_er <= active & r[5];
  end
endmodule

// File: test/phy_link_monitor_rgmii_cfg_regs_tb_top.sv
`timescale 1ns/1ps
module phy_link_monitor_rgmii_cfg_regs_tb_top;
  reg        clk, sys_rst, ce, reg_wr, reg_rd, strap_pin_a, strap_pin_b, strap_pin_c;
  reg        auto_polarity, link_up_conform, link_monitor_up, phy_send_data, comm_ready_raw;
  reg        training_active, tx_fifo_overflow, tx_fifo_underflow, pcs_rx_ctl, lpi_exit;
  reg        mac_active;
  reg [11:0] reg_addr;
  reg [15:0] reg_wdata;
  reg [2:0]  sqi_value;
  reg [3:0]  fail_event, pcs_rxd;
  wire [15:0] reg_rdata;
  wire        enhanced_rx_en, line_polarity, comm_ready, link_up_sel, rgmii_enable;
  wire        rx_clk_shift, tx_clk_shift, mac_tx_en, mac_tx_er, pcs_tx_en, pcs_tx_er;
  wire        rgmii_rx_ctl;
  wire [2:0]  tx_sync_fifo_threshold;
  wire [3:0]  mac_txd, pcs_txd, rgmii_rxd;
  integer    bad_count = 0, n_compared = 0, seed = 99, i, k;
  reg [43:0] t;
  reg [5:0]  ptx, prx;
  reg [31:0] r;
  reg [1:0]  l;

  phy_link_monitor_rgmii_cfg_regs #(.HYST_2MS_CYC(16'd8), .HYST_500US_CYC(16'd4),
    .HYST_1MS_CYC(16'd6), .HYST_4MS_CYC(16'd10), .TRAIN_TICK_CYC(16'd4)) DUT (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_pin_a(strap_pin_a),
    .strap_pin_b(strap_pin_b), .strap_pin_c(strap_pin_c), .enhanced_rx_en(enhanced_rx_en),
    .auto_polarity(auto_polarity), .line_polarity(line_polarity),
    .link_up_conform(link_up_conform), .link_monitor_up(link_monitor_up),
    .phy_send_data(phy_send_data), .comm_ready_raw(comm_ready_raw), .comm_ready(comm_ready),
    .link_up_sel(link_up_sel), .sqi_value(sqi_value), .fail_event(fail_event),
    .training_active(training_active), .tx_sync_fifo_threshold(tx_sync_fifo_threshold),
    .tx_fifo_overflow(tx_fifo_overflow), .tx_fifo_underflow(tx_fifo_underflow),
    .rgmii_enable(rgmii_enable), .rx_clk_shift(rx_clk_shift), .tx_clk_shift(tx_clk_shift),
    .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er), .pcs_txd(pcs_txd),
    .pcs_tx_en(pcs_tx_en), .pcs_tx_er(pcs_tx_er), .pcs_rxd(pcs_rxd), .pcs_rx_ctl(pcs_rx_ctl),
    .lpi_exit(lpi_exit), .rgmii_rxd(rgmii_rxd), .rgmii_rx_ctl(rgmii_rx_ctl));
  mac_tx_model mac (.clk(clk), .sys_rst(sys_rst), .active(mac_active), .mac_txd(mac_txd),
    .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function [3:0] rev(input [3:0] v);
    rev = {v[0], v[1], v[2], v[3]};
  endfunction
  function integer hn(input [1:0] c);
    hn = (c == 2'd0) ? 8 : (c == 2'd1) ? 4 : (c == 2'd2) ? 6 : 10;
  endfunction
  // address, reset value, read-back after writing all ones (16'h1080 for 12'h4a0)
  function [43:0] tab(input integer n);
    case (n)
      0: tab = {12'h553, 16'h0000, 16'hffff};
      1: tab = {12'h560, 16'h07e4, 16'h3fff};
      2: tab = {12'h561, 16'h0000, 16'h0000};
      3: tab = {12'h562, 16'h0000, 16'h0000};
      4: tab = {12'h600, 16'h0030 | {12'h0, strap_pin_c, 3'h0}, 16'h007f};
      5: tab = {12'h601, 16'h0000, 16'h0000};
      6: tab = {12'h602, 14'h0, strap_pin_c & strap_pin_b,
                {strap_pin_c, strap_pin_b, strap_pin_a} == 3'b101 ||
                {strap_pin_c, strap_pin_b, strap_pin_a} == 3'b110, 16'h0003};
      7: tab = {12'h603, 16'h0000, 16'h0003};
      8: tab = {12'h608, 16'h007b, 16'hffff};
      9: tab = {12'h4a0, 16'h1000, 16'h1080};
      default: tab = {12'h7f0, 16'h0000, 16'h0000};
    endcase
  endfunction
  function [4:0] exp_rx(input [3:0] c, input [1:0] m, input [5:0] p);
    if (!c[3]) exp_rx = 5'h0;
    else if (p[5]) exp_rx = {m[1], m[0] ? 4'h0 : 4'h1};
    else exp_rx = {p[4], c[1] ? rev(p[3:0]) : p[3:0]};
  endfunction

  task end_of_test;
    begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdchk(input [11:0] a, input [15:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  task ev(input [5:0] e);
    begin
      @(posedge clk);
      {tx_fifo_overflow, tx_fifo_underflow, fail_event} <= e;
      @(posedge clk);
      {tx_fifo_overflow, tx_fifo_underflow, fail_event} <= 6'h0;
    end
  endtask

  initial begin
    {ce, sys_rst, strap_pin_c, strap_pin_b, strap_pin_a} = 5'b11101;
    {reg_wr, reg_rd, reg_addr, reg_wdata, auto_polarity, link_up_conform} = 0;
    {link_monitor_up, phy_send_data, comm_ready_raw, training_active, mac_active} = 0;
    {tx_fifo_overflow, tx_fifo_underflow, fail_event, sqi_value, pcs_rxd} = 0;
    {pcs_rx_ctl, lpi_exit} = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (i = 0; i < 11; i = i + 1) begin
      t = tab(i);
      rdchk(t[43:32], t[31:16]);
    end
    chk({tx_sync_fifo_threshold, rgmii_enable}, {3'h3, strap_pin_c});
    for (i = 0; i < 11; i = i + 1) begin
      t = tab(i);
      wr(t[43:32], (i == 9) ? 16'h1080 : 16'hffff);
      rdchk(t[43:32], t[15:0]);
    end
    chk({enhanced_rx_en, tx_sync_fifo_threshold, rx_clk_shift, tx_clk_shift}, 6'h3f);
    wr(12'h4a0, 16'h1000);
    #1 chk(enhanced_rx_en, 0);
    for (i = 0; i < 8; i = i + 1) begin
      wr(12'h553, {2'b00, i[2:1], 12'h000});
      auto_polarity <= i[0];
      #1 chk(line_polarity, i[2] ? i[1] : i[0]);
    end
    mac_active <= 1'b1;
    for (k = 0; k < 16; k = k + 1) begin
      l = k[1:0] ^ k[3:2];
      wr(12'h600, {12'h003, k[3:0]});
      wr(12'h603, {14'h0, l});
      repeat (12) begin
        @(posedge clk);
        ptx = {mac_tx_en, mac_tx_er, mac_txd};
        prx = {lpi_exit, pcs_rx_ctl, pcs_rxd};
        r = $random(seed);
        {lpi_exit, pcs_rx_ctl, pcs_rxd} <= {r[5] & r[6], r[4:0]};
        t[5:0] = k[3] ? {ptx[5], ptx[4] & !k[0], k[2] ? rev(ptx[3:0]) : ptx[3:0]} : 6'h0;
        #1 chk({pcs_tx_en, pcs_tx_er, pcs_txd}, t[5:0]);
        chk({rgmii_rx_ctl, rgmii_rxd}, exp_rx(k[3:0], l, prx));
      end
    end
    mac_active <= 1'b0;
    wr(12'h560, 16'h07e4);
    {link_up_conform, sqi_value} <= 4'hf;
    repeat (3) ev(6'h02);
    wr(12'h560, 16'h0764);
    ev(6'h02);
    ev(6'h01);
    ev(6'h04);
    ev(6'h08);
    @(posedge clk) sqi_value <= 3'h2;
    @(posedge clk) sqi_value <= 3'h1;
    @(posedge clk) link_up_conform <= 1'b0;
    ev(6'h02);
    rdchk(12'h561, 16'h0407);
    for (i = 0; i < 32; i = i + 1) begin
      if (i[2:0] == 3'd0) wr(12'h560, {3'h0, i[4:3], 11'h7e4});
      @(posedge clk) {phy_send_data, link_monitor_up, link_up_conform} <= i[2:0];
      #1 chk(link_up_sel, (i[4:3] == 2'd3) ? 1'b0 : i[i[4:3]]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(12'h560, {3'h0, 2'b11, 6'h3f, i[1:0], 3'h4});
      comm_ready_raw <= 1'b1;
      repeat (hn(i[1:0]) - 1) @(posedge clk);
      #1 chk(comm_ready, 0);
      for (k = 0; k < 3 && comm_ready !== 1'b1; k = k + 1) @(posedge clk) #1;
      chk({comm_ready, link_up_sel}, 2'b11);
      if (comm_ready !== 1'b1) end_of_test;
      rdchk(12'h562, 16'h8000);
      @(posedge clk) comm_ready_raw <= 1'b0;
      @(posedge clk) #1 chk(comm_ready, 0);
    end
    @(posedge clk) training_active <= 1'b1;
    repeat (14) @(posedge clk);
    training_active <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(12'h562, 16'h0003);
    for (i = 1; i < 4; i = i + 1) begin
      ev({i[1:0], 4'h0});
      rdchk(12'h601, i[15:0]);
      rdchk(12'h601, 16'h0000);
    end
    end_of_test;
  end
endmodule

bind phy_link_monitor_rgmii_cfg_regs link_monitor_checker chk_u (.clk(clk),
  .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comm_ready_raw(comm_ready_raw),
  .comm_ready(comm_ready), .link_up_sel(link_up_sel), .link_up_conform(link_up_conform),
  .link_monitor_up(link_monitor_up), .phy_send_data(phy_send_data),
  .rgmii_enable(rgmii_enable), .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er),
  .pcs_tx_en(pcs_tx_en), .pcs_tx_er(pcs_tx_er), .pcs_txd(pcs_txd), .lpi_exit(lpi_exit),
  .rgmii_rxd(rgmii_rxd), .rgmii_rx_ctl(rgmii_rx_ctl));
